// *** hdl/dri_pkg.sv ***
// Purpose: Shared constants and types for the reload/indirect DMA channel.
// Assumes: APB register access with 32-bit data, one word per register.
// Notes:   Offsets, the control field layout and the pointer, count and control reset values live here.
package dri_pkg;

	localparam int          ADDR_W      = 32;
	localparam int          DATA_W      = 32;
	localparam int          REG_AW      = 8;
	localparam int          GROUP_W     = 2;

	// Register byte offsets on the APB side.
	localparam logic [7:0]  OFS_SRC     = 8'h00;
	localparam logic [7:0]  OFS_DST     = 8'h04;
	localparam logic [7:0]  OFS_CNT     = 8'h08;
	localparam logic [7:0]  OFS_CTRL    = 8'h0C;
	localparam logic [7:0]  OFS_STAT    = 8'h10;
	localparam logic [7:0]  OFS_ISTAT   = 8'h14;
	localparam logic [7:0]  OFS_ICLR    = 8'h18;
	localparam logic [7:0]  OFS_IEN     = 8'h1C;

	localparam logic [31:0] RST_ADDR    = 32'h0000_0000;
	localparam logic [31:0] RST_CNT     = 32'h0000_0000;
	localparam logic [10:0] RST_CTRL    = 11'h000;
	localparam logic [1:0]  GROUP_LAST  = 2'h3;
	localparam logic [31:0] CNT_ONE     = 32'h0000_0001;

	// Step modes for source and destination addresses.
	localparam logic [1:0]  STEP_FIXED  = 2'h0;
	localparam logic [1:0]  STEP_INC    = 2'h1;
	localparam logic [1:0]  STEP_DEC    = 2'h2;

	// Transfer sizes.
	localparam logic [1:0]  SIZE_BYTE   = 2'h0;
	localparam logic [1:0]  SIZE_WORD   = 2'h1;
	localparam logic [1:0]  SIZE_LONG   = 2'h2;

	// Channel control register layout, bit 10 downward.
	typedef struct packed {
		logic [1:0] transfer_size_sel;
		logic [1:0] dest_step_mode;
		logic [1:0] source_step_mode;
		logic       burst_mode;
		logic       indirect_mode;
		logic       reload_enable;
		logic       end_interrupt_enable;
		logic       channel_enable_bit;
	} dri_ctrl_t;

	// One access on the system bus.
	typedef struct packed {
		logic              req;
		logic              we;
		logic [1:0]        size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dri_mem_req_t;

	typedef enum {ST_IDLE, ST_ARB, ST_PTR, ST_RD, ST_WR, ST_NEXT} dri_state_t;

	function automatic logic [ADDR_W-1:0] size_bytes(input logic [1:0] sz);
		case (sz)
			SIZE_BYTE: size_bytes = 32'h0000_0001;
			SIZE_WORD: size_bytes = 32'h0000_0002;
			default:   size_bytes = 32'h0000_0004;
		endcase
	endfunction : size_bytes

endpackage : dri_pkg

// *** hdl/dri_addr_step.sv ***
// Purpose: Next-address calculator for one address pointer.
// Assumes: Pure combinational, used for both source and destination.
// Notes:   Mode 3 is treated as fixed, the same as mode 0.
`timescale 1ns/1ps
module dri_addr_step #(
	parameter int AW = 32
) (
	// Current pointer and its controls
	input  wire logic [AW-1:0] addr,
	input  wire logic [1:0]    mode,
	input  wire logic [1:0]    size,
	// Stepped pointer
	output logic [AW-1:0]      addr_next
);
	logic [AW-1:0] step;

	always_comb begin
		step = dri_pkg::size_bytes(size);
		case (mode)
			dri_pkg::STEP_INC: addr_next = addr + step;
			dri_pkg::STEP_DEC: addr_next = addr - step;
			default:           addr_next = addr;
		endcase
	end

endmodule : dri_addr_step

// *** hdl/dri_channel.sv ***
// Purpose: One DMA channel with source address reload and indirect addressing.
// Assumes: APB slave for registers; a simple request/ack system bus master port;
//          bus ownership granted by the processor via bus_req/bus_grant.
// Notes:   All ports are on pclk; the peripheral request comes from on-chip logic.
`timescale 1ns/1ps
module dri_channel #(
	parameter int AW = dri_pkg::ADDR_W,
	parameter int DW = dri_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [DW-1:0] pwdata,
	output logic               pready,
	output logic [DW-1:0]      prdata,
	output logic               pslverr,
	// Peripheral request and flag clear
	input  wire logic          dma_request,
	output logic               request_flag_clear,
	// Bus arbitration towards the processor
	output logic               bus_req,
	input  wire logic          bus_grant,
	// System bus master
	output dri_pkg::dri_mem_req_t mem_out,
	input  wire logic          mem_ack,
	input  wire logic [DW-1:0] mem_rdata,
	// Interrupt
	output logic               irq
);

	dri_pkg::dri_state_t   state_r;
	dri_pkg::dri_ctrl_t    ctrl_r;
	dri_pkg::dri_mem_req_t mem_r;
	logic [AW-1:0]         src_r;
	logic [AW-1:0]         src_start_r;
	logic [AW-1:0]         dst_r;
	logic [31:0]           cnt_r;
	logic [dri_pkg::GROUP_W-1:0] grp_r;
	logic                  istat_r;
	logic                  ien_r;
	logic                  pready_r;
	logic [DW-1:0]         prdata_r;
	logic                  pslverr_r;
	logic                  flag_clr_r;
	logic                  bus_req_r;
	logic                  irq_r;

	logic [AW-1:0]         src_next;
	logic [AW-1:0]         dst_next;
	logic [1:0]            src_size;
	logic                  apb_wr;
	logic                  apb_rd;
	logic                  done_xfer;
	logic                  last_cnt;
	logic                  grp_end;
	logic                  set_end_irq;
	logic                  reg_hit;
	logic                  wr_src;
	logic                  wr_dst;
	logic                  wr_cnt;
	logic                  wr_ctrl;
	logic                  wr_iclr;
	logic                  wr_ien;
	logic                  eng_idle;

	assign pready             = pready_r;
	assign prdata             = prdata_r;
	assign pslverr            = pslverr_r;
	assign request_flag_clear = flag_clr_r;
	assign bus_req            = bus_req_r;
	assign mem_out            = mem_r;
	assign irq                = irq_r;

	// The answer comes one cycle into the access phase, so data leaves a flop.
	assign apb_wr = psel & penable & pwrite & ~pready_r;
	assign apb_rd = psel & penable & ~pwrite & ~pready_r;

	// One offset compare serves every register write decode below.
	function automatic logic ofs_is(input logic [7:0] a, input logic [7:0] ofs);
		ofs_is = (a == ofs);
	endfunction : ofs_is

	assign wr_src   = apb_wr & ofs_is(paddr, dri_pkg::OFS_SRC);
	assign wr_dst   = apb_wr & ofs_is(paddr, dri_pkg::OFS_DST);
	assign wr_cnt   = apb_wr & ofs_is(paddr, dri_pkg::OFS_CNT);
	assign wr_ctrl  = apb_wr & ofs_is(paddr, dri_pkg::OFS_CTRL);
	assign wr_iclr  = apb_wr & ofs_is(paddr, dri_pkg::OFS_ICLR);
	assign wr_ien   = apb_wr & ofs_is(paddr, dri_pkg::OFS_IEN);
	// Pointer and count writes are refused while the engine owns them.
	assign eng_idle = (state_r == dri_pkg::ST_IDLE);

	// Unmapped offsets still complete with one wait state, flagged by pslverr.
	always_comb begin
		case (paddr)
			dri_pkg::OFS_SRC, dri_pkg::OFS_DST, dri_pkg::OFS_CNT, dri_pkg::OFS_CTRL,
			dri_pkg::OFS_STAT, dri_pkg::OFS_ISTAT, dri_pkg::OFS_ICLR,
			dri_pkg::OFS_IEN: reg_hit = 1'b1;
			default:          reg_hit = 1'b0;
		endcase
	end

	// Pointer fetches step the source by a longword, whatever the data size.
	assign src_size = ctrl_r.indirect_mode ? dri_pkg::SIZE_LONG
	                                       : ctrl_r.transfer_size_sel;

	dri_addr_step #(
		.AW(AW)
	) u_src_step (
		.addr     (src_r),
		.mode     (ctrl_r.source_step_mode),
		.size     (src_size),
		.addr_next(src_next)
	);

	dri_addr_step #(
		.AW(AW)
	) u_dst_step (
		.addr     (dst_r),
		.mode     (ctrl_r.dest_step_mode),
		.size     (ctrl_r.transfer_size_sel),
		.addr_next(dst_next)
	);

	assign done_xfer   = (state_r == dri_pkg::ST_NEXT);
	assign last_cnt    = (cnt_r == dri_pkg::CNT_ONE);
	assign grp_end     = (grp_r == dri_pkg::GROUP_LAST);
	assign set_end_irq = done_xfer & last_cnt & ctrl_r.end_interrupt_enable;

	// APB response.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= dri_pkg::RST_ADDR;
		end else begin
			pready_r  <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & ~reg_hit;
			if (apb_rd) begin
				case (paddr)
					dri_pkg::OFS_SRC:   prdata_r <= src_r;
					dri_pkg::OFS_DST:   prdata_r <= dst_r;
					dri_pkg::OFS_CNT:   prdata_r <= cnt_r;
					dri_pkg::OFS_CTRL:  prdata_r <= {21'h0, ctrl_r};
					dri_pkg::OFS_STAT:  prdata_r <= {29'h0, grp_r, !eng_idle};
					dri_pkg::OFS_ISTAT: prdata_r <= {31'h0, istat_r};
					dri_pkg::OFS_IEN:   prdata_r <= {31'h0, ien_r};
					default:            prdata_r <= 32'h0000_0000;
				endcase
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	// Channel control. Request source selection lives outside this channel,
	// so changing it with the channel enabled is the user's hazard.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= dri_pkg::RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_r <= pwdata[10:0];
		end
	end

	// Transfer counter modulo four, cleared on an enable edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grp_r <= '0;
		end else if (wr_ctrl && pwdata[0]
		             && !ctrl_r.channel_enable_bit) begin
			grp_r <= '0;
		end else if (done_xfer) begin
			grp_r <= grp_r + 2'h1;
		end
	end

	// Source address, with its reload copy. Software writes are ignored
	// while the channel is moving data, so the engine owns the pointer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_r       <= dri_pkg::RST_ADDR;
			src_start_r <= dri_pkg::RST_ADDR;
		end else if (wr_src && eng_idle) begin
			src_r       <= pwdata;
			src_start_r <= pwdata;
		end else if (done_xfer) begin
			if (ctrl_r.reload_enable && grp_end) begin
				src_r <= src_start_r;
			end else begin
				src_r <= src_next;
			end
		end
	end

	// Destination address steps regardless of reload.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dst_r <= dri_pkg::RST_ADDR;
		end else if (wr_dst && eng_idle) begin
			dst_r <= pwdata;
		end else if (done_xfer) begin
			dst_r <= dst_next;
		end
	end

	// Transfer count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= dri_pkg::RST_CNT;
		end else if (wr_cnt && eng_idle) begin
			cnt_r <= pwdata;
		end else if (done_xfer) begin
			cnt_r <= cnt_r - dri_pkg::CNT_ONE;
		end
	end

	// Interrupt status, enable and output. A set in the same cycle as a
	// clear wins, so no end-of-count event is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_r <= 1'b0;
			ien_r   <= 1'b0;
			irq_r   <= 1'b0;
		end else begin
			if (wr_ien) begin
				ien_r <= pwdata[0];
			end
			if (set_end_irq) begin
				istat_r <= 1'b1;
			end else if (wr_iclr && pwdata[0]) begin
				istat_r <= 1'b0;
			end
			irq_r <= istat_r & ien_r;
		end
	end

	// Peripheral request flag clear pulse. Count end and group end can fall
	// on one transfer; they share a single pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_clr_r <= 1'b0;
		end else begin
			flag_clr_r <= done_xfer & (last_cnt
			              | (ctrl_r.reload_enable & grp_end));
		end
	end

	// Transfer engine and system bus requests.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= dri_pkg::ST_IDLE;
			bus_req_r <= 1'b0;
			mem_r     <= '0;
		end else begin
			case (state_r)
				dri_pkg::ST_IDLE: begin
					// The flag clear takes a cycle to reach the peripheral, so a
					// request seen during the pulse is stale and must not restart.
					if (ctrl_r.channel_enable_bit && dma_request && !flag_clr_r
					    && cnt_r != dri_pkg::RST_CNT) begin
						bus_req_r <= 1'b1;
						state_r   <= dri_pkg::ST_ARB;
					end
				end
				dri_pkg::ST_ARB: begin
					if (bus_grant) begin
						mem_r.req  <= 1'b1;
						mem_r.we   <= 1'b0;
						mem_r.addr <= src_r;
						if (ctrl_r.indirect_mode) begin
							mem_r.size <= dri_pkg::SIZE_LONG;
							state_r    <= dri_pkg::ST_PTR;
						end else begin
							mem_r.size <= ctrl_r.transfer_size_sel;
							state_r    <= dri_pkg::ST_RD;
						end
					end
				end
				dri_pkg::ST_PTR: begin
					if (mem_ack) begin
						mem_r.addr <= mem_rdata;
						mem_r.size <= ctrl_r.transfer_size_sel;
						state_r    <= dri_pkg::ST_RD;
					end
				end
				dri_pkg::ST_RD: begin
					if (mem_ack) begin
						// Write data is the read word as is; narrow sizes use the low lanes.
						mem_r.we    <= 1'b1;
						mem_r.addr  <= dst_r;
						mem_r.size  <= ctrl_r.transfer_size_sel;
						mem_r.wdata <= mem_rdata;
						state_r     <= dri_pkg::ST_WR;
					end
				end
				dri_pkg::ST_WR: begin
					if (mem_ack) begin
						mem_r.req <= 1'b0;
						mem_r.we  <= 1'b0;
						state_r   <= dri_pkg::ST_NEXT;
					end
				end
				dri_pkg::ST_NEXT: begin
					// Pointers update this cycle; the next access reads them after.
					if (last_cnt || (ctrl_r.reload_enable && grp_end)
					    || !ctrl_r.burst_mode || !ctrl_r.channel_enable_bit) begin
						bus_req_r <= 1'b0;
						state_r   <= dri_pkg::ST_IDLE;
					end else begin
						state_r <= dri_pkg::ST_ARB;
					end
				end
				default: begin
					state_r   <= dri_pkg::ST_IDLE;
					bus_req_r <= 1'b0;
				end
			endcase
		end
	end

endmodule : dri_channel

// *** tb/dri_channel_monitor.sv ***
// Purpose: Port-level checks for the reload/indirect DMA channel.
// Assumes: One pclk domain, presetn active low.
// Notes:   The control word is mirrored from completed APB writes.
`timescale 1ns/1ps
module dri_channel_monitor (
	// Clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	// APB
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic                  pready,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	// Engine
	input wire logic                  request_flag_clear,
	input wire logic                  bus_req,
	input wire dri_pkg::dri_mem_req_t mem_out,
	input wire logic                  mem_ack,
	input wire logic [31:0]           mem_rdata,
	input wire logic                  irq
);
	logic [10:0] ctrl_r;
	logic [31:0] rd_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 11'h000;
		end else if (psel && penable && pready && pwrite && paddr == dri_pkg::OFS_CTRL) begin
			ctrl_r <= pwdata[10:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_r <= 32'h0000_0000;
		end else if (mem_ack && !mem_out.we) begin
			rd_r <= mem_rdata;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_apb_wait; psel && penable && !pready |=> pready; endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("APB answer late");
	property p_apb_pulse; pready |=> !pready; endproperty
	a_apb_pulse: assert property (p_apb_pulse) else $error("pready longer than one cycle");
	property p_slverr; pslverr |-> pready; endproperty
	a_slverr: assert property (p_slverr) else $error("pslverr without pready");
	property p_rdata_idle; !pready |-> prdata == 32'h0000_0000; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
	property p_own; mem_out.req |-> bus_req; endproperty
	a_own: assert property (p_own) else $error("bus access without bus request");
	property p_hold; mem_out.req && !mem_ack |=> $stable(mem_out); endproperty
	a_hold: assert property (p_hold) else $error("bus access changed before ack");
	property p_wdata; mem_out.req && mem_out.we |-> mem_out.wdata == rd_r; endproperty
	a_wdata: assert property (p_wdata) else $error("write data differs from read");
	property p_ptr_long;
		$rose(mem_out.req) && ctrl_r[3] |-> mem_out.size == dri_pkg::SIZE_LONG;
	endproperty
	a_ptr_long: assert property (p_ptr_long) else $error("pointer read not long");
	property p_wsize; mem_out.req && mem_out.we |-> mem_out.size == ctrl_r[10:9]; endproperty
	a_wsize: assert property (p_wsize) else $error("write size wrong");
	property p_release; request_flag_clear |-> ##[0:2] !bus_req; endproperty
	a_release: assert property (p_release) else $error("bus kept after stop");
	c_flag: cover property (request_flag_clear);
	c_irq: cover property ($rose(irq));
	c_ind: cover property ($rose(mem_out.req) && ctrl_r[3]);
endmodule : dri_channel_monitor

// *** tb/dri_bus_model.sv ***
// Purpose: System bus, arbiter and requesting peripheral beside the channel.
// Assumes: Read data is the address with a fixed pattern folded in.
// Notes:   Between answers the read bus toggles so data sampled one cycle late never matches.
`timescale 1ns/1ps
module dri_bus_model (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Arbitration and system bus
	input  wire logic                  bus_req,
	output logic                       bus_grant,
	input  wire dri_pkg::dri_mem_req_t mem_out,
	output logic                       mem_ack,
	output logic [31:0]                mem_rdata,
	// Peripheral flag and pacing
	input  wire logic                  raise,
	input  wire logic                  request_flag_clear,
	output logic                       dma_request,
	input  wire logic                  slow
);
	logic [1:0]  wait_r;
	logic [31:0] last_rd_addr;
	logic [31:0] last_wr_addr;
	logic [31:0] last_wr_data;
	logic [1:0]  last_wr_size;
	int          n_wr;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_grant <= 1'b0;
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0000_0000;
			wait_r <= 2'h0;
			n_wr <= 0;
			dma_request <= 1'b0;
		end else begin
			bus_grant <= bus_req;
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (raise) begin
				dma_request <= 1'b1;
			end else if (request_flag_clear) begin
				dma_request <= 1'b0;
			end
			if (mem_out.req && !mem_ack) begin
				if (slow && wait_r != 2'h3) begin
					wait_r <= wait_r + 2'h1;
				end else begin
					wait_r <= 2'h0;
					mem_ack <= 1'b1;
					if (mem_out.we) begin
						last_wr_addr <= mem_out.addr;
						last_wr_data <= mem_out.wdata;
						last_wr_size <= mem_out.size;
						n_wr <= n_wr + 1;
					end else begin
						last_rd_addr <= mem_out.addr;
						mem_rdata <= mem_out.addr ^ 32'hA5A5_0000;
					end
				end
			end
		end
	end
endmodule : dri_bus_model

// *** tb/dma_reload_indirect_channel_bench.sv ***
// Purpose: Self-checking bench for the reload/indirect DMA channel.
// Assumes: APB answers after one wait state; the bus model paces the engine.
// Notes:   The peripheral flag is raised by the bench and cleared by the channel.
`timescale 1ns/1ps
module dma_reload_indirect_channel_bench;
	logic                  pclk;
	logic                  presetn;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [7:0]            paddr;
	logic [31:0]           pwdata;
	logic                  pready;
	logic [31:0]           prdata;
	logic                  pslverr;
	logic                  dma_request;
	logic                  request_flag_clear;
	logic                  bus_req;
	logic                  bus_grant;
	dri_pkg::dri_mem_req_t mem_out;
	logic                  mem_ack;
	logic [31:0]           mem_rdata;
	logic                  irq;
	logic                  raise;
	logic                  slow;
	int                    failures;
	int                    samples_checked;
	int                    clr_count = 0;
	logic [31:0]           q;
	logic                  e;
	dri_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .dma_request(dma_request), .request_flag_clear(request_flag_clear),
		.bus_req(bus_req), .bus_grant(bus_grant), .mem_out(mem_out), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .irq(irq));
	dri_bus_model bus_u (.pclk(pclk), .presetn(presetn), .bus_req(bus_req),
		.bus_grant(bus_grant), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.raise(raise), .request_flag_clear(request_flag_clear), .dma_request(dma_request),
		.slow(slow));
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		if (request_flag_clear === 1'b1) begin
			clr_count <= clr_count + 1;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(q, exp);
	endtask : rd
	task automatic setup(input logic [31:0] s, input logic [31:0] d, input logic [31:0] c,
		input logic [31:0] ctl);
		apb(1'b1, dri_pkg::OFS_CTRL, 32'h0000_0000);
		apb(1'b1, dri_pkg::OFS_SRC, s);
		apb(1'b1, dri_pkg::OFS_DST, d);
		apb(1'b1, dri_pkg::OFS_CNT, c);
		apb(1'b1, dri_pkg::OFS_CTRL, ctl);
	endtask : setup
	task automatic run_group;
		@(posedge pclk);
		raise <= 1'b1;
		@(posedge pclk);
		raise <= 1'b0;
		while (request_flag_clear !== 1'b1) begin
			@(posedge pclk);
		end
		repeat (4) @(posedge pclk);
	endtask : run_group
	task automatic tally_and_finish;
		$display("Checked %0d values, %0d mismatches", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		tally_and_finish();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, raise, slow} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		failures = 0;
		samples_checked = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(dri_pkg::OFS_STAT, 32'h0000_0000);
		rd(dri_pkg::OFS_CTRL, 32'h0000_0000);
		rd(dri_pkg::OFS_ISTAT, 32'h0000_0000);
		apb(1'b0, 8'h20, 32'h0000_0000);
		check({31'h0, e}, 32'h0000_0001);
		// Reload on, burst, long, source up, destination down, eight transfers.
		setup(32'h0000_0100, 32'h0000_0400, 32'h0000_0008, 32'h0000_0537);
		run_group();
		rd(dri_pkg::OFS_SRC, 32'h0000_0100);
		rd(dri_pkg::OFS_DST, 32'h0000_03F0);
		rd(dri_pkg::OFS_CNT, 32'h0000_0004);
		rd(dri_pkg::OFS_STAT, 32'h0000_0000);
		check({31'h0, bus_req}, 32'h0000_0000);
		check(bus_u.n_wr, 32'h0000_0004);
		rd(dri_pkg::OFS_ISTAT, 32'h0000_0000);
		check(clr_count, 32'h0000_0001);
		run_group();
		rd(dri_pkg::OFS_SRC, 32'h0000_0100);
		rd(dri_pkg::OFS_DST, 32'h0000_03E0);
		rd(dri_pkg::OFS_CNT, 32'h0000_0000);
		rd(dri_pkg::OFS_ISTAT, 32'h0000_0001);
		check(clr_count, 32'h0000_0002);
		apb(1'b1, dri_pkg::OFS_IEN, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, dri_pkg::OFS_ICLR, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0000_0000);
		// Reload off with a slow bus: all eight run in one burst.
		slow <= 1'b1;
		setup(32'h0000_0100, 32'h0000_0400, 32'h0000_0008, 32'h0000_0531);
		run_group();
		rd(dri_pkg::OFS_SRC, 32'h0000_0120);
		rd(dri_pkg::OFS_DST, 32'h0000_03E0);
		check(bus_u.n_wr, 32'h0000_0010);
		check(clr_count, 32'h0000_0003);
		check({31'h0, irq}, 32'h0000_0000);
		// Indirect, byte data, cycle steal, one transfer.
		slow <= 1'b0;
		setup(32'h0000_0200, 32'h0000_0080, 32'h0000_0001, 32'h0000_0029);
		run_group();
		rd(dri_pkg::OFS_SRC, 32'h0000_0204);
		rd(dri_pkg::OFS_DST, 32'h0000_0080);
		check(bus_u.last_rd_addr, 32'hA5A5_0200);
		check(bus_u.last_wr_data, 32'h0000_0200);
		check({30'h0, bus_u.last_wr_size}, {30'h0, dri_pkg::SIZE_BYTE});
		check(bus_u.last_wr_addr, 32'h0000_0080);
		// Word data, source down, destination up, cycle steal, one transfer.
		setup(32'h0000_0300, 32'h0000_0500, 32'h0000_0001, 32'h0000_02C1);
		run_group();
		rd(dri_pkg::OFS_SRC, 32'h0000_02FE);
		rd(dri_pkg::OFS_DST, 32'h0000_0502);
		check(bus_u.last_wr_data, 32'hA5A5_0300);
		check({30'h0, bus_u.last_wr_size}, {30'h0, dri_pkg::SIZE_WORD});
		tally_and_finish();
	end
endmodule : dma_reload_indirect_channel_bench
bind dri_channel dri_channel_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .request_flag_clear(request_flag_clear),
	.bus_req(bus_req), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq));
